// *** track_bank_params.svh ***
// Purpose: offsets, field positions, reset values and bus codes of the result tracking bank
// Assumes: included by bare name from every file that needs a number
// Notes:   offsets are register indices; the bus byte address is four times the index
`ifndef TRACK_BANK_PARAMS_SVH
`define TRACK_BANK_PARAMS_SVH

// ======================================================
// tracking register indices (read/write)
`define IDX_CURRENT_PEAK       8'h40
`define IDX_CURRENT_FLOOR      8'h42
`define IDX_WATT_PEAK          8'h44
`define IDX_WATT_FLOOR         8'h46
`define IDX_RAIL_PEAK          8'h50
`define IDX_RAIL_FLOOR         8'h52
`define IDX_THERMAL_PEAK       8'h54
`define IDX_THERMAL_FLOOR      8'h56
`define IDX_LOGIC_SUPPLY_PEAK  8'h58
`define IDX_LOGIC_SUPPLY_FLOOR 8'h5a

// ======================================================
// live result and history indices (read only)
`define IDX_CURRENT_VALUE      8'h90
`define IDX_WATT_VALUE         8'h93
`define IDX_RAIL_POTENTIAL     8'ha0
`define IDX_THERMAL_WORD       8'ha2
`define IDX_LOGIC_SUPPLY_WORD  8'ha4
`define IDX_CURRENT_PAST_1     8'hb0
`define IDX_CURRENT_PAST_2     8'hb3
`define IDX_CURRENT_PAST_3     8'hb6
`define IDX_CURRENT_PAST_4     8'hb9
`define IDX_CURRENT_PAST_5     8'hbc

// ======================================================
// reset values and field positions
`define PEAK_RESET             16'h8000
`define FLOOR_RESET            16'h7fff
`define LIVE24_RESET           24'h00_0000
`define LIVE16_RESET           16'h0000
`define TRACK_MSB              17
`define TRACK_LSB              2
`define IDX_MSB                9
`define IDX_LSB                2

// ======================================================
// bus response codes
`define RESP_OKAY              2'h0
`define RESP_SLVERR            2'h2

`endif

// *** measurement_pkg.sv ***
// Purpose: shared types of the result tracking bank
// Assumes: numbers live in track_bank_params.svh
// Notes:   all results are signed two's complement
package measurement_pkg;
	typedef logic signed [15:0] word16_type;
	typedef logic signed [23:0] word24_type;
	typedef enum {TRK_CURRENT, TRK_WATT, TRK_RAIL, TRK_THERMAL, TRK_SUPPLY, TRK_COUNT} tracked_type;
endpackage : measurement_pkg

// *** track_link_if.sv ***
// Purpose: link between the bank and one peak/floor keeper
// Assumes: one instance per tracked quantity
// Notes:   wr_data already carries the byte-lane merge
interface track_link_if;
	measurement_pkg::word16_type sample;
	logic                        update;
	logic                        wr_peak;
	logic                        wr_floor;
	measurement_pkg::word16_type wr_data;
	measurement_pkg::word16_type peak;
	measurement_pkg::word16_type floor;

	modport keeper (input sample, input update, input wr_peak, input wr_floor, input wr_data,
		output peak, output floor);
	modport owner (output sample, output update, output wr_peak, output wr_floor, output wr_data,
		input peak, input floor);
endinterface : track_link_if

// *** peak_floor_tracker.sv ***
// Purpose: keeps the signed peak and floor of one quantity since reset
// Assumes: update is a one-cycle pulse per conversion
// Notes:   a host write in the same cycle as an update wins for that word
`include "track_bank_params.svh"

module peak_floor_tracker
(
	// clock and reset
	input wire logic          aclk,
	input wire logic          aresetn,
	// link to the bank
	track_link_if.keeper      link
);

	measurement_pkg::word16_type peak_ff;
	measurement_pkg::word16_type floor_ff;
	measurement_pkg::word16_type nxt_peak;
	measurement_pkg::word16_type nxt_floor;

	// ======================================================
	// next values
	always_comb
	begin
		nxt_peak  = peak_ff;
		nxt_floor = floor_ff;
		if (link.update && (link.sample > peak_ff))
		begin
			nxt_peak = link.sample;
		end
		if (link.update && (link.sample < floor_ff))
		begin
			nxt_floor = link.sample;
		end
		if (link.wr_peak)
		begin
			nxt_peak = link.wr_data;
		end
		if (link.wr_floor)
		begin
			nxt_floor = link.wr_data;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			peak_ff  <= `PEAK_RESET;
			floor_ff <= `FLOOR_RESET;
		end
		else
		begin
			peak_ff  <= nxt_peak;
			floor_ff <= nxt_floor;
		end
	end

	assign link.peak  = peak_ff;
	assign link.floor = floor_ff;

	// ======================================================
	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_PEAK_GROWS:
	assert property (link.update && !link.wr_peak |=> peak_ff >= $past(link.sample) && peak_ff >= $past(peak_ff))
		else $error("peak missed a larger sample");
	AST_FLOOR_SHRINKS:
	assert property (link.update && !link.wr_floor |=> floor_ff <= $past(link.sample)
		&& floor_ff <= $past(floor_ff))
		else $error("floor missed a smaller sample");
	AST_RESET_LOAD:
	assert property ($rose(aresetn) |-> peak_ff == `PEAK_RESET && floor_ff == `FLOOR_RESET)
		else $error("tracker reset values wrong");
endmodule : peak_floor_tracker

// *** measurement_result_tracking_bank.sv ***
// Purpose: live measurement results, current history and signed peak/floor words behind AXI4-Lite
// Assumes: conversion inputs come from logic on aclk; conv_valid pulses once per conversion
// Notes:   byte address = register index * 4; data sits in the low bits, upper bits read zero
`include "track_bank_params.svh"

module measurement_result_tracking_bank
#(
	parameter int ADDR_W = 12
)
(
	// clock and reset
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	// axi4-lite write address
	input  wire logic [ADDR_W-1:0]           awaddr,
	input  wire logic [2:0]                  awprot,
	input  wire logic                        awvalid,
	output logic                             awready,
	// axi4-lite write data
	input  wire logic [31:0]                 wdata,
	input  wire logic [3:0]                  wstrb,
	input  wire logic                        wvalid,
	output logic                             wready,
	// axi4-lite write response
	output logic [1:0]                       bresp,
	output logic                             bvalid,
	input  wire logic                        bready,
	// axi4-lite read address
	input  wire logic [ADDR_W-1:0]           araddr,
	input  wire logic [2:0]                  arprot,
	input  wire logic                        arvalid,
	output logic                             arready,
	// axi4-lite read data
	output logic [31:0]                      rdata,
	output logic [1:0]                       rresp,
	output logic                             rvalid,
	input  wire logic                        rready,
	// conversion results
	input  wire logic                        conv_valid,
	input  wire measurement_pkg::word24_type cur_sample,
	input  wire logic signed [17:0]          cur_track,
	input  wire measurement_pkg::word24_type watt_sample,
	input  wire logic signed [17:0]          watt_track,
	input  wire measurement_pkg::word16_type rail_sample,
	input  wire measurement_pkg::word16_type thermal_sample,
	input  wire measurement_pkg::word16_type supply_sample
);

	localparam int NTRK  = measurement_pkg::TRK_COUNT;
	localparam int NPAST = 5;

	// ======================================================
	// live results and history
	measurement_pkg::word24_type cur_ff;
	measurement_pkg::word24_type watt_ff;
	measurement_pkg::word16_type rail_ff;
	measurement_pkg::word16_type thermal_ff;
	measurement_pkg::word16_type supply_ff;
	measurement_pkg::word24_type past_ff [NPAST];
	measurement_pkg::word24_type nxt_cur;
	measurement_pkg::word24_type nxt_watt;
	measurement_pkg::word16_type nxt_rail;
	measurement_pkg::word16_type nxt_thermal;
	measurement_pkg::word16_type nxt_supply;
	measurement_pkg::word24_type nxt_past [NPAST];

	// one strobe moves the whole set so a read never sees a half-updated mix
	always_comb
	begin
		nxt_cur     = cur_ff;
		nxt_watt    = watt_ff;
		nxt_rail    = rail_ff;
		nxt_thermal = thermal_ff;
		nxt_supply  = supply_ff;
		for (int k = 0; k < NPAST; k++)
		begin
			nxt_past[k] = past_ff[k];
		end
		if (conv_valid)
		begin
			nxt_cur     = cur_sample;
			nxt_watt    = watt_sample;
			nxt_rail    = rail_sample;
			nxt_thermal = thermal_sample;
			nxt_supply  = supply_sample;
			nxt_past[0] = cur_ff;
			for (int k = 1; k < NPAST; k++)
			begin
				nxt_past[k] = past_ff[k-1];
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cur_ff     <= `LIVE24_RESET;
			watt_ff    <= `LIVE24_RESET;
			rail_ff    <= `LIVE16_RESET;
			thermal_ff <= `LIVE16_RESET;
			supply_ff  <= `LIVE16_RESET;
			for (int k = 0; k < NPAST; k++)
			begin
				past_ff[k] <= `LIVE24_RESET;
			end
		end
		else
		begin
			cur_ff     <= nxt_cur;
			watt_ff    <= nxt_watt;
			rail_ff    <= nxt_rail;
			thermal_ff <= nxt_thermal;
			supply_ff  <= nxt_supply;
			for (int k = 0; k < NPAST; k++)
			begin
				past_ff[k] <= nxt_past[k];
			end
		end
	end

	// ======================================================
	// write channel state
	logic                   aw_got_ff;
	logic                   w_got_ff;
	logic [ADDR_W-1:0]      awaddr_ff;
	logic [31:0]            wdata_ff;
	logic [3:0]             wstrb_ff;
	logic                   bvalid_ff;
	logic [1:0]             bresp_ff;
	logic                   nxt_aw_got;
	logic                   nxt_w_got;
	logic [ADDR_W-1:0]      nxt_awaddr;
	logic [31:0]            nxt_wdata;
	logic [3:0]             nxt_wstrb;
	logic                   nxt_bvalid;
	logic [1:0]             nxt_bresp;
	logic                   do_write;
	logic [7:0]             wr_idx;
	logic [8:0]             wr_sel;
	logic                   wr_hit_rw;
	logic                   wr_hit_ro;

	localparam logic [7:0] PEAK_IDX [NTRK] = '{`IDX_CURRENT_PEAK, `IDX_WATT_PEAK, `IDX_RAIL_PEAK,
		`IDX_THERMAL_PEAK, `IDX_LOGIC_SUPPLY_PEAK};
	localparam logic [7:0] FLOOR_IDX [NTRK] = '{`IDX_CURRENT_FLOOR, `IDX_WATT_FLOOR, `IDX_RAIL_FLOOR,
		`IDX_THERMAL_FLOOR, `IDX_LOGIC_SUPPLY_FLOOR};

	// index of a byte address; out-of-window or misaligned addresses yield no hit
	function automatic logic [8:0] to_idx(input logic [ADDR_W-1:0] addr);
		logic ok;
		ok = (addr[1:0] == 2'h0) && ((addr >> (`IDX_MSB + 1)) == '0);
		return {ok, addr[`IDX_MSB:`IDX_LSB]};
	endfunction : to_idx

	function automatic logic is_live(input logic [7:0] idx);
		return idx inside {`IDX_CURRENT_VALUE, `IDX_WATT_VALUE, `IDX_RAIL_POTENTIAL, `IDX_THERMAL_WORD,
			`IDX_LOGIC_SUPPLY_WORD, `IDX_CURRENT_PAST_1, `IDX_CURRENT_PAST_2, `IDX_CURRENT_PAST_3,
			`IDX_CURRENT_PAST_4, `IDX_CURRENT_PAST_5};
	endfunction : is_live

	function automatic logic is_track(input logic [7:0] idx);
		return idx inside {`IDX_CURRENT_PEAK, `IDX_CURRENT_FLOOR, `IDX_WATT_PEAK, `IDX_WATT_FLOOR,
			`IDX_RAIL_PEAK, `IDX_RAIL_FLOOR, `IDX_THERMAL_PEAK, `IDX_THERMAL_FLOOR,
			`IDX_LOGIC_SUPPLY_PEAK, `IDX_LOGIC_SUPPLY_FLOOR};
	endfunction : is_track

	function automatic measurement_pkg::word16_type merge16(input measurement_pkg::word16_type old,
		input logic [31:0] d, input logic [3:0] s);
		return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction : merge16

	assign wr_sel    = to_idx(awaddr_ff);
	assign wr_idx    = wr_sel[7:0];
	assign wr_hit_rw = wr_sel[8] && is_track(wr_idx);
	assign wr_hit_ro = wr_sel[8] && is_live(wr_idx);
	assign do_write  = aw_got_ff && w_got_ff && !bvalid_ff;
	assign awready   = !aw_got_ff;
	assign wready    = !w_got_ff;

	always_comb
	begin
		nxt_aw_got = aw_got_ff;
		nxt_w_got  = w_got_ff;
		nxt_awaddr = awaddr_ff;
		nxt_wdata  = wdata_ff;
		nxt_wstrb  = wstrb_ff;
		nxt_bvalid = bvalid_ff;
		nxt_bresp  = bresp_ff;
		if (awvalid && awready)
		begin
			nxt_aw_got = 1'b1;
			nxt_awaddr = awaddr;
		end
		if (wvalid && wready)
		begin
			nxt_w_got = 1'b1;
			nxt_wdata = wdata;
			nxt_wstrb = wstrb;
		end
		if (bvalid_ff && bready)
		begin
			nxt_bvalid = 1'b0;
		end
		if (do_write)
		begin
			nxt_aw_got = 1'b0;
			nxt_w_got  = 1'b0;
			nxt_bvalid = 1'b1;
			// writes to read-only words are answered but change nothing
			nxt_bresp  = (wr_hit_rw || wr_hit_ro) ? `RESP_OKAY : `RESP_SLVERR;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got_ff <= 1'b0;
			w_got_ff  <= 1'b0;
			awaddr_ff <= '0;
			wdata_ff  <= 32'h0000_0000;
			wstrb_ff  <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff  <= `RESP_OKAY;
		end
		else
		begin
			aw_got_ff <= nxt_aw_got;
			w_got_ff  <= nxt_w_got;
			awaddr_ff <= nxt_awaddr;
			wdata_ff  <= nxt_wdata;
			wstrb_ff  <= nxt_wstrb;
			bvalid_ff <= nxt_bvalid;
			bresp_ff  <= nxt_bresp;
		end
	end

	assign bvalid = bvalid_ff;
	assign bresp  = bresp_ff;

	// ======================================================
	// peak and floor keepers
	track_link_if trk [NTRK] ();
	logic signed [15:0] cur_track_msb;
	logic signed [15:0] watt_track_msb;

	// only the upper bits of the 18-bit internal words are tracked
	assign cur_track_msb   = cur_track[`TRACK_MSB:`TRACK_LSB];
	assign watt_track_msb  = watt_track[`TRACK_MSB:`TRACK_LSB];
	assign trk[measurement_pkg::TRK_CURRENT].sample = cur_track_msb;
	assign trk[measurement_pkg::TRK_WATT].sample    = watt_track_msb;
	assign trk[measurement_pkg::TRK_RAIL].sample    = rail_sample;
	assign trk[measurement_pkg::TRK_THERMAL].sample = thermal_sample;
	assign trk[measurement_pkg::TRK_SUPPLY].sample  = supply_sample;

	for (genvar g = 0; g < NTRK; g++)
	begin : gen_trk
		assign trk[g].update   = conv_valid;
		assign trk[g].wr_peak  = do_write && wr_hit_rw && (wr_idx == PEAK_IDX[g]);
		assign trk[g].wr_floor = do_write && wr_hit_rw && (wr_idx == FLOOR_IDX[g]);
		assign trk[g].wr_data  = merge16((wr_idx == PEAK_IDX[g]) ? trk[g].peak : trk[g].floor,
			wdata_ff, wstrb_ff);
		peak_floor_tracker u_tracker
		(
			.aclk    (aclk),
			.aresetn (aresetn),
			.link    (trk[g])
		);
	end

	// ======================================================
	// read channel
	logic        rvalid_ff;
	logic [1:0]  rresp_ff;
	logic [31:0] rdata_ff;
	logic        nxt_rvalid;
	logic [1:0]  nxt_rresp;
	logic [31:0] nxt_rdata;
	logic [31:0] rd_word;
	logic        rd_hit;
	logic [8:0]  rd_sel;

	assign rd_sel  = to_idx(araddr);
	assign arready = !rvalid_ff;

	always_comb
	begin
		rd_hit  = rd_sel[8];
		rd_word = 32'h0000_0000;
		case (rd_sel[7:0])
			`IDX_CURRENT_PEAK:       rd_word = {16'h0000, trk[0].peak};
			`IDX_CURRENT_FLOOR:      rd_word = {16'h0000, trk[0].floor};
			`IDX_WATT_PEAK:          rd_word = {16'h0000, trk[1].peak};
			`IDX_WATT_FLOOR:         rd_word = {16'h0000, trk[1].floor};
			`IDX_RAIL_PEAK:          rd_word = {16'h0000, trk[2].peak};
			`IDX_RAIL_FLOOR:         rd_word = {16'h0000, trk[2].floor};
			`IDX_THERMAL_PEAK:       rd_word = {16'h0000, trk[3].peak};
			`IDX_THERMAL_FLOOR:      rd_word = {16'h0000, trk[3].floor};
			`IDX_LOGIC_SUPPLY_PEAK:  rd_word = {16'h0000, trk[4].peak};
			`IDX_LOGIC_SUPPLY_FLOOR: rd_word = {16'h0000, trk[4].floor};
			`IDX_CURRENT_VALUE:      rd_word = {8'h00, cur_ff};
			`IDX_WATT_VALUE:         rd_word = {8'h00, watt_ff};
			`IDX_RAIL_POTENTIAL:     rd_word = {16'h0000, rail_ff};
			`IDX_THERMAL_WORD:       rd_word = {16'h0000, thermal_ff};
			`IDX_LOGIC_SUPPLY_WORD:  rd_word = {16'h0000, supply_ff};
			`IDX_CURRENT_PAST_1:     rd_word = {8'h00, past_ff[0]};
			`IDX_CURRENT_PAST_2:     rd_word = {8'h00, past_ff[1]};
			`IDX_CURRENT_PAST_3:     rd_word = {8'h00, past_ff[2]};
			`IDX_CURRENT_PAST_4:     rd_word = {8'h00, past_ff[3]};
			`IDX_CURRENT_PAST_5:     rd_word = {8'h00, past_ff[4]};
			default:                 rd_hit  = 1'b0;
		endcase
	end

	always_comb
	begin
		nxt_rvalid = rvalid_ff;
		nxt_rresp  = rresp_ff;
		nxt_rdata  = rdata_ff;
		if (rvalid_ff && rready)
		begin
			nxt_rvalid = 1'b0;
		end
		if (arvalid && arready)
		begin
			nxt_rvalid = 1'b1;
			nxt_rdata  = rd_hit ? rd_word : 32'h0000_0000;
			nxt_rresp  = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_ff <= 1'b0;
			rresp_ff  <= `RESP_OKAY;
			rdata_ff  <= 32'h0000_0000;
		end
		else
		begin
			rvalid_ff <= nxt_rvalid;
			rresp_ff  <= nxt_rresp;
			rdata_ff  <= nxt_rdata;
		end
	end

	assign rvalid = rvalid_ff;
	assign rresp  = rresp_ff;
	assign rdata  = rdata_ff;

	// ======================================================
	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_CUR_LOAD:
	assert property (conv_valid |=> cur_ff == $past(cur_sample))
		else $error("current result not loaded");
	AST_HIST_FIRST:
	assert property (conv_valid |=> past_ff[0] == $past(cur_ff))
		else $error("history slot one not taken from newest");
	AST_HIST_DEEP:
	assert property (conv_valid ##1 conv_valid |=> past_ff[4] == $past(past_ff[2], 2))
		else $error("history not shifted deeper");
	AST_RAIL_LOAD:
	assert property (conv_valid |=> rail_ff == $past(rail_sample) && supply_ff == $past(supply_sample))
		else $error("voltage results not loaded");
	AST_WATT_THERMAL_LOAD:
	assert property (conv_valid |=> watt_ff == $past(watt_sample) && thermal_ff == $past(thermal_sample))
		else $error("power or temperature result not loaded");
	AST_TRACK_MSB:
	assert property (conv_valid && !trk[0].wr_peak && cur_track_msb > trk[0].peak
		|=> trk[0].peak == $past(cur_track_msb))
		else $error("current peak not taken from upper bits");
	AST_RO_HOLD:
	assert property (!conv_valid |=> $stable(cur_ff) && $stable(past_ff[0]) && $stable(watt_ff))
		else $error("read only word changed without a conversion");
	AST_SET_TOGETHER:
	assert property (conv_valid && (cur_sample != cur_ff) |=> $changed(cur_ff) && past_ff[0] == $past(cur_ff))
		else $error("result and history did not move together");
	AST_PEAK_WRITE:
	assert property (do_write && wr_hit_rw && wr_idx == `IDX_CURRENT_PEAK && wstrb_ff[1:0] == 2'h3
		|=> trk[0].peak == $past(wdata_ff[15:0]) && bvalid && bresp == `RESP_OKAY)
		else $error("current peak write lost");
	AST_READ_ANSWER:
	assert property (arvalid && arready |=> rvalid and (!rready |=> rvalid && $stable(rdata)))
		else $error("read answer missing or unstable");

	COV_NEW_PEAK:   cover property (conv_valid && cur_track_msb > trk[0].peak ##1 conv_valid);
	COV_READ:       cover property (arvalid && arready ##1 rvalid && rready);
	COV_WRITE:      cover property (do_write ##1 bvalid && bready);
	COV_STALL_READ: cover property (rvalid && !rready ##1 rvalid && rready);
endmodule : measurement_result_tracking_bank

// *** host_axi_model.sv ***
// Purpose: AXI4-Lite host that reads and writes the tracking bank
// Assumes: one transfer at a time, called just after a rising edge
// Notes:   handshakes are sampled at the rising edge; one idle edge follows each transfer
module host_axi_model
(
	// clock
	input  wire logic        aclk,
	// write channels
	output logic [11:0]      awaddr,
	output logic [2:0]       awprot,
	output logic             awvalid,
	input  wire logic        awready,
	output logic [31:0]      wdata,
	output logic [3:0]       wstrb,
	output logic             wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	output logic             bready,
	// read channels
	output logic [11:0]      araddr,
	output logic [2:0]       arprot,
	output logic             arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	output logic             rready
);
	timeunit 1ns;
	timeprecision 1ps;

	// ======================================================
	// bus tasks
	initial
	begin
		{awaddr, awprot, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arprot, arvalid, rready} = '0;
	end

	task automatic write_reg(input logic [7:0] idx, input logic [31:0] d, output logic [1:0] resp);
		awaddr  <= {2'b00, idx, 2'b00};
		wdata   <= d;
		wstrb   <= 4'h3;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end
		while (!bvalid);
		resp = bresp;
		bready <= 1'b0;
		// idle edge so a following call never reassigns bready in this time step
		@(posedge aclk);
	endtask : write_reg

	task automatic read_reg(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] resp);
		araddr  <= {2'b00, idx, 2'b00};
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
		end
		while (!rvalid);
		d = rdata;
		resp = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask : read_reg
endmodule : host_axi_model

// *** measurement_result_tracking_bank_bench.sv ***
// Purpose: self-checking bench of the result tracking bank
// Assumes: host model speaks AXI4-Lite; conversions driven here
// Notes:   samples straddle zero so an unsigned compare would show
module measurement_result_tracking_bank_bench;
	timeunit 1ns;
	timeprecision 1ps;

	logic                        aclk = 1'b0;
	logic                        aresetn = 1'b0;
	logic [11:0]                 awaddr, araddr;
	logic [2:0]                  awprot, arprot;
	logic                        awvalid, awready, wvalid, wready, bvalid, bready;
	logic                        arvalid, arready, rvalid, rready, conv_valid;
	logic [31:0]                 wdata, rdata, rd;
	logic [3:0]                  wstrb;
	logic [1:0]                  bresp, rresp, resp;
	measurement_pkg::word24_type cur_sample, watt_sample;
	logic signed [17:0]          cur_track, watt_track;
	measurement_pkg::word16_type rail_sample, thermal_sample, supply_sample;
	logic [23:0]                 c;
	int                          err_count = 0;
	int                          comparisons = 0;
	int                          cycles = 0;
	logic [7:0] track_idx [10] = '{8'h40, 8'h42, 8'h44, 8'h46, 8'h50, 8'h52, 8'h54, 8'h56, 8'h58, 8'h5a};
	logic [7:0] live_idx [10]  = '{8'h90, 8'h93, 8'ha0, 8'ha2, 8'ha4, 8'hb0, 8'hb3, 8'hb6, 8'hb9, 8'hbc};

	measurement_result_tracking_bank DUT (.aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata,
		.wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .conv_valid, .cur_sample, .cur_track, .watt_sample, .watt_track,
		.rail_sample, .thermal_sample, .supply_sample);
	host_axi_model host (.aclk, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

	always #5 aclk = ~aclk;

	// ======================================================
	// checking and closing
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run

	// a stuck handshake would hang the host tasks
	always @(posedge aclk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			err_count++;
			complete_run();
		end
	end

	// ======================================================
	// tests
	initial
	begin
		conv_valid = 1'b0;
		{cur_sample, watt_sample, cur_track, watt_track} = '0;
		{rail_sample, thermal_sample, supply_sample} = '0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int i = 0; i < 10; i++)
		begin
			host.read_reg(track_idx[i], rd, resp);
			chk(rd, (i % 2) ? 32'h0000_7fff : 32'h0000_8000);
			host.read_reg(live_idx[i], rd, resp);
			chk(rd, 32'h0000_0000);
		end
		// back-to-back conversions from -2 up to 3
		conv_valid <= 1'b1;
		for (int k = 0; k < 6; k++)
		begin
			c = 24'hff_fffe + 24'(k);
			cur_sample     <= c;
			watt_sample    <= c;
			cur_track      <= {c[15:0], 2'b01};
			watt_track     <= {c[15:0], 2'b01};
			rail_sample    <= c[15:0];
			thermal_sample <= c[15:0];
			supply_sample  <= c[15:0];
			@(posedge aclk);
		end
		conv_valid <= 1'b0;
		for (int i = 0; i < 10; i++)
		begin
			host.read_reg(track_idx[i], rd, resp);
			chk(rd, (i % 2) ? 32'h0000_fffe : 32'h0000_0003);
			host.read_reg(live_idx[i], rd, resp);
			chk(rd, (i < 5) ? 32'h0000_0003 : {8'h00, 24'hff_fffe + 24'(9 - i)});
		end
		// host-side fine power: voltage times current, both read back
		host.read_reg(8'ha0, rd, resp);
		c = rd[23:0];
		host.read_reg(8'h90, rd, resp);
		chk(32'(c) * rd, 32'h0000_0009);
		host.write_reg(8'h40, 32'h0000_1234, resp);
		chk({30'h0, resp}, 32'h0000_0000);
		host.read_reg(8'h40, rd, resp);
		chk(rd, 32'h0000_1234);
		host.write_reg(8'h90, 32'h0000_5555, resp);
		chk({30'h0, resp}, 32'h0000_0000);
		host.read_reg(8'h90, rd, resp);
		chk(rd, 32'h0000_0003);
		host.read_reg(8'h41, rd, resp);
		chk({30'h0, resp}, 32'h0000_0002);
		chk(rd, 32'h0000_0000);
		complete_run();
	end
endmodule : measurement_result_tracking_bank_bench
